// ==== rtl/serial_fifo_consts.vh ====
`ifndef SERIAL_FIFO_CONSTS_VH
`define SERIAL_FIFO_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define OFS_FIFO_CONFIG         12'he00
`define OFS_FIFO_STATUS         12'he04
`define OFS_FIFO_TRIGGER_CONFIG 12'he08
`define OFS_IRQ_MASK            12'he10
`define OFS_TX_DATA             12'he20
`define OFS_RX_DATA             12'he30

// ****************************************
// Config fields
// ****************************************
`define BIT_RX_FLUSH_CMD        17
`define BIT_TX_FLUSH_CMD        16
`define BIT_RX_DMA_ENABLE       13
`define BIT_TX_DMA_ENABLE       12
`define POS_SIZE_LO             4
`define SIZE_FOUR_BY_SIXTEEN    2'h1

// ****************************************
// Status fields
// ****************************************
`define POS_RX_FILL_LO          16
`define POS_TX_FILL_LO          8
`define BIT_RX_FULL             7
`define BIT_RX_HAS_DATA         6
`define BIT_TX_HAS_ROOM         5
`define BIT_TX_DRAINED          4
`define BIT_FUNC_IRQ            3
`define BIT_RX_OVERFLOW         1
`define BIT_TX_FAULT            0

// ****************************************
// Trigger and mask writable bits
// ****************************************
`define TRIGGER_WRITE_MASK      32'h000f0f03
`define IRQ_MASK_WRITE_MASK     32'h0000000b

// ****************************************
// Reset values and depth
// ****************************************
`define RESET_WORD              32'h00000000
`define FIFO_DEPTH              3'h4

`endif

// ==== rtl/serial_fifo_status_logic.v ====
// Functional notes
// - Receive fill count in status bits 20-16; zero means rx flags both zero.
// - Receive full sets rx full and has-data; nonzero count is exact entry count.
// - Transmit fill count in status bits 12-8; zero means drained and room both one.
// - Transmit full clears drained and room flags; nonzero count is exact entry count.
// - Status bit 7 high while receive FIFO full; reader must drain promptly.
// - Status bit 6 high when receive data is available, low when empty.
// - Status bit 5 low when transmit FIFO full, high when room remains.
// - Status bit 4 high when transmit FIFO empty, even if last word still shifting.
// - Status bit 3 mirrors the peripheral function interrupt line.
// - Sticky bit 1 set on receive push into full FIFO; write one clears.
// - Sticky bit 0 set on push into full transmit FIFO; write one clears.
// - Sticky bit 0 also set when transmit word needed while FIFO empty.
// - Reserved status bits 31-21, 15-13 and 2 are ignored on write.
// - FIFO status register decoded at offset e04.
// - Trigger settings register decoded at offset e08.
// - Each FIFO holds four sixteen-bit entries; size field reads back that setting.
// - Flush command bits discard FIFO contents and return levels to zero.
// - DMA requests: receive while not empty, transmit while not full, when enabled.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`include "serial_fifo_consts.vh"

module serial_fifo_status_logic (
	// Clock and reset
	input  wire        CLK,
	input  wire        SYS_RST,
	// Register port
	input  wire [11:0] REG_ADDR,
	input  wire [31:0] REG_WDATA,
	input  wire        REG_WR,
	input  wire        REG_RD,
	output reg  [31:0] REG_RDATA,
	// Peripheral engine transmit side
	input  wire        TX_WORD_REQ,
	output reg  [15:0] TX_WORD,
	output reg         TX_WORD_VALID,
	// Peripheral engine receive side
	input  wire        RX_WORD_PUSH,
	input  wire [15:0] RX_WORD,
	input  wire        FUNC_IRQ,
	// DMA requests and interrupt
	output reg         RX_DMA_REQ,
	output reg         TX_DMA_REQ,
	output reg         IRQ
);

	// ****************************************
	// Storage and state
	// ****************************************
	reg  [15:0] tx_mem [0:3];
	reg  [15:0] rx_mem [0:3];
	reg  [1:0]  tx_wr_ptr;
	reg  [1:0]  tx_rd_ptr;
	reg  [2:0]  tx_fill_count;
	reg  [1:0]  rx_wr_ptr;
	reg  [1:0]  rx_rd_ptr;
	reg  [2:0]  rx_fill_count;
	reg         rx_overflow_error;
	reg         tx_fault_error;
	reg         rx_dma_request_enable;
	reg         tx_dma_request_enable;
	reg  [31:0] fifo_trigger_config;
	reg  [31:0] irq_mask;
	reg  [31:0] next_rdata;
	reg  [2:0]  next_tx_fill;
	reg  [2:0]  next_rx_fill;
	reg         next_rx_overflow_error;
	reg         next_tx_fault_error;
	reg         next_rx_dma_enable;
	reg         next_tx_dma_enable;
	reg         next_rx_dma_req;
	reg         next_tx_dma_req;
	reg         next_irq;

	// ****************************************
	// Decode and flags
	// ****************************************
	wire        wr_config  = REG_WR && (REG_ADDR == `OFS_FIFO_CONFIG);
	wire        wr_status  = REG_WR && (REG_ADDR == `OFS_FIFO_STATUS);
	wire        wr_trigger = REG_WR && (REG_ADDR == `OFS_FIFO_TRIGGER_CONFIG);
	wire        wr_mask    = REG_WR && (REG_ADDR == `OFS_IRQ_MASK);
	wire        wr_txdata  = REG_WR && (REG_ADDR == `OFS_TX_DATA);
	wire        rd_rxdata  = REG_RD && (REG_ADDR == `OFS_RX_DATA);

	wire        tx_flush   = wr_config && REG_WDATA[`BIT_TX_FLUSH_CMD];
	wire        rx_flush   = wr_config && REG_WDATA[`BIT_RX_FLUSH_CMD];

	wire        rx_full_flag = (rx_fill_count == `FIFO_DEPTH);
	wire        rx_has_data  = (rx_fill_count != 3'h0);
	wire        tx_has_room  = (tx_fill_count != `FIFO_DEPTH);
	wire        tx_drained   = (tx_fill_count == 3'h0);

	wire        tx_push    = wr_txdata && tx_has_room;
	wire        tx_ovf     = wr_txdata && !tx_has_room;
	wire        tx_pop     = TX_WORD_REQ && !tx_drained;
	wire        tx_udf     = TX_WORD_REQ && tx_drained;
	wire        rx_push    = RX_WORD_PUSH && !rx_full_flag;
	wire        rx_ovf     = RX_WORD_PUSH && rx_full_flag;
	wire        rx_pop     = rd_rxdata && rx_has_data;

	// ****************************************
	// Status word
	// ****************************************
	wire [31:0] fifo_status = {
		11'h000,
		2'h0,
		rx_fill_count,
		3'h0,
		2'h0,
		tx_fill_count,
		rx_full_flag,
		rx_has_data,
		tx_has_room,
		tx_drained,
		FUNC_IRQ,
		1'b0,
		rx_overflow_error,
		tx_fault_error
	};

	// ****************************************
	// Config word
	// ****************************************
	wire [31:0] fifo_config = {
		14'h0000,
		2'h0,
		2'h0,
		rx_dma_request_enable,
		tx_dma_request_enable,
		6'h00,
		`SIZE_FOUR_BY_SIXTEEN,
		4'h0
	};

	// ****************************************
	// Transmit level
	// ****************************************
	always @* begin
		next_tx_fill = tx_fill_count;
		if (tx_push && !tx_pop) begin
			next_tx_fill = tx_fill_count + 3'h1;
		end else if (tx_pop && !tx_push) begin
			next_tx_fill = tx_fill_count - 3'h1;
		end
	end

	// ****************************************
	// Receive level
	// ****************************************
	always @* begin
		next_rx_fill = rx_fill_count;
		if (rx_push && !rx_pop) begin
			next_rx_fill = rx_fill_count + 3'h1;
		end else if (rx_pop && !rx_push) begin
			next_rx_fill = rx_fill_count - 3'h1;
		end
	end

	// ****************************************
	// Read mux
	// ****************************************
	always @* begin
		case (REG_ADDR)
			`OFS_FIFO_CONFIG: begin
				next_rdata = fifo_config;
			end
			`OFS_FIFO_STATUS: begin
				next_rdata = fifo_status;
			end
			`OFS_FIFO_TRIGGER_CONFIG: begin
				next_rdata = fifo_trigger_config;
			end
			`OFS_IRQ_MASK: begin
				next_rdata = irq_mask;
			end
			`OFS_RX_DATA: begin
				next_rdata = {16'h0000, rx_mem[rx_rd_ptr]};
			end
			default: begin
				next_rdata = 32'h00000000;
			end
		endcase
	end

	// ****************************************
	// Sticky error next values
	// ****************************************
	always @* begin
		next_rx_overflow_error = rx_overflow_error;
		if (rx_ovf) begin
			next_rx_overflow_error = 1'b1;
		end else if (wr_status && REG_WDATA[`BIT_RX_OVERFLOW]) begin
			next_rx_overflow_error = 1'b0;
		end
		next_tx_fault_error = tx_fault_error;
		if (tx_ovf || tx_udf) begin
			next_tx_fault_error = 1'b1;
		end else if (wr_status && REG_WDATA[`BIT_TX_FAULT]) begin
			next_tx_fault_error = 1'b0;
		end
	end

	// ****************************************
	// Config next values
	// ****************************************
	always @* begin
		next_rx_dma_enable = rx_dma_request_enable;
		next_tx_dma_enable = tx_dma_request_enable;
		if (wr_config) begin
			next_rx_dma_enable = REG_WDATA[`BIT_RX_DMA_ENABLE];
			next_tx_dma_enable = REG_WDATA[`BIT_TX_DMA_ENABLE];
		end
	end

	// ****************************************
	// DMA and interrupt next values
	// ****************************************
	always @* begin
		next_rx_dma_req = 1'b0;
		if (next_rx_dma_enable && !rx_flush && (next_rx_fill != 3'h0)) begin
			next_rx_dma_req = 1'b1;
		end
		next_tx_dma_req = 1'b0;
		if (next_tx_dma_enable && (tx_flush || (next_tx_fill != `FIFO_DEPTH))) begin
			next_tx_dma_req = 1'b1;
		end
		next_irq = |(irq_mask[3:0] & fifo_status[3:0]);
	end

	// ****************************************
	// Transmit storage
	// ****************************************
	always @(posedge CLK) begin
		if (!SYS_RST && !tx_flush && tx_push) begin
			tx_mem[tx_wr_ptr] <= REG_WDATA[15:0];
		end
	end

	// ****************************************
	// Transmit FIFO pointers
	// ****************************************
	always @(posedge CLK) begin
		if (SYS_RST) begin
			tx_wr_ptr     <= 2'h0;
			tx_rd_ptr     <= 2'h0;
			tx_fill_count <= 3'h0;
		end else if (tx_flush) begin
			tx_wr_ptr     <= 2'h0;
			tx_rd_ptr     <= 2'h0;
			tx_fill_count <= 3'h0;
		end else begin
			if (tx_push) begin
				tx_wr_ptr <= tx_wr_ptr + 2'h1;
			end
			if (tx_pop) begin
				tx_rd_ptr <= tx_rd_ptr + 2'h1;
			end
			tx_fill_count <= next_tx_fill;
		end
	end

	// ****************************************
	// Transmit word output
	// ****************************************
	always @(posedge CLK) begin
		if (SYS_RST) begin
			TX_WORD       <= 16'h0000;
			TX_WORD_VALID <= 1'b0;
		end else begin
			if (tx_pop && !tx_flush) begin
				TX_WORD <= tx_mem[tx_rd_ptr];
			end
			TX_WORD_VALID <= tx_pop && !tx_flush;
		end
	end

	// ****************************************
	// Receive storage
	// ****************************************
	always @(posedge CLK) begin
		if (!SYS_RST && !rx_flush && rx_push) begin
			rx_mem[rx_wr_ptr] <= RX_WORD;
		end
	end

	// ****************************************
	// Receive FIFO pointers
	// ****************************************
	always @(posedge CLK) begin
		if (SYS_RST) begin
			rx_wr_ptr     <= 2'h0;
			rx_rd_ptr     <= 2'h0;
			rx_fill_count <= 3'h0;
		end else if (rx_flush) begin
			rx_wr_ptr     <= 2'h0;
			rx_rd_ptr     <= 2'h0;
			rx_fill_count <= 3'h0;
		end else begin
			if (rx_push) begin
				rx_wr_ptr <= rx_wr_ptr + 2'h1;
			end
			if (rx_pop) begin
				rx_rd_ptr <= rx_rd_ptr + 2'h1;
			end
			rx_fill_count <= next_rx_fill;
		end
	end

	// ****************************************
	// Sticky errors
	// ****************************************
	always @(posedge CLK) begin
		if (SYS_RST) begin
			rx_overflow_error <= 1'b0;
			tx_fault_error    <= 1'b0;
		end else begin
			rx_overflow_error <= next_rx_overflow_error;
			tx_fault_error    <= next_tx_fault_error;
		end
	end

	// ****************************************
	// DMA enables
	// ****************************************
	always @(posedge CLK) begin
		if (SYS_RST) begin
			rx_dma_request_enable <= 1'b0;
			tx_dma_request_enable <= 1'b0;
		end else begin
			rx_dma_request_enable <= next_rx_dma_enable;
			tx_dma_request_enable <= next_tx_dma_enable;
		end
	end

	// ****************************************
	// Trigger and mask registers
	// ****************************************
	always @(posedge CLK) begin
		if (SYS_RST) begin
			fifo_trigger_config <= `RESET_WORD;
			irq_mask            <= `RESET_WORD;
		end else begin
			if (wr_trigger) begin
				fifo_trigger_config <= REG_WDATA & `TRIGGER_WRITE_MASK;
			end
			if (wr_mask) begin
				irq_mask <= REG_WDATA & `IRQ_MASK_WRITE_MASK;
			end
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	always @(posedge CLK) begin
		if (SYS_RST) begin
			REG_RDATA <= `RESET_WORD;
		end else if (REG_RD) begin
			REG_RDATA <= next_rdata;
		end else begin
			REG_RDATA <= 32'h00000000;
		end
	end

	// ****************************************
	// DMA requests and interrupt
	// ****************************************
	always @(posedge CLK) begin
		if (SYS_RST) begin
			RX_DMA_REQ <= 1'b0;
			TX_DMA_REQ <= 1'b0;
			IRQ        <= 1'b0;
		end else begin
			RX_DMA_REQ <= next_rx_dma_req;
			TX_DMA_REQ <= next_tx_dma_req;
			IRQ        <= next_irq;
		end
	end

endmodule // serial_fifo_status_logic

// ==== sim/serial_fifo_status_logic_asserts.sv ====
`timescale 1ns/10ps
module serial_fifo_checker (
	// Clock, reset, register port
	input wire        CLK, SYS_RST, REG_WR, REG_RD,
	input wire [11:0] REG_ADDR,
	input wire [31:0] REG_WDATA, REG_RDATA,
	// Engine, DMA, interrupt
	input wire        TX_WORD_REQ, TX_WORD_VALID, RX_WORD_PUSH, FUNC_IRQ,
	input wire [15:0] TX_WORD, RX_WORD,
	input wire        RX_DMA_REQ, TX_DMA_REQ, IRQ
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	wire st = REG_RD && REG_ADDR == 12'he04;
	rdata_idle_a: assert property (!REG_RD |=> REG_RDATA == 32'h0)
		else $error("rdata not idle");
	rx_flags_a: assert property (st |=> REG_RDATA[7] == (REG_RDATA[20:16] == 5'h4)
		&& REG_RDATA[6] == (REG_RDATA[20:16] != 5'h0)) else $error("rx flags");
	tx_flags_a: assert property (st |=> REG_RDATA[4] == (REG_RDATA[12:8] == 5'h0)
		&& REG_RDATA[5] == (REG_RDATA[12:8] != 5'h4)) else $error("tx flags");
	func_irq_a: assert property (st && $stable(FUNC_IRQ) |=> REG_RDATA[3] == $past(FUNC_IRQ))
		else $error("irq bit");
	unmapped_zero_a: assert property (REG_RD && !(REG_ADDR inside
		{12'he00, 12'he04, 12'he08, 12'he10, 12'he30}) |=> REG_RDATA == 32'h0) else $error("unmapped");
	tx_valid_cause_a: assert property (TX_WORD_VALID |-> $past(TX_WORD_REQ))
		else $error("tx valid");
	tx_word_hold_a: assert property (!TX_WORD_VALID |-> $stable(TX_WORD))
		else $error("tx word moved");
	rx_dma_rise_a: assert property ($rose(RX_DMA_REQ) |-> $past(RX_WORD_PUSH) || $past(REG_WR))
		else $error("rx dma");
	tx_dma_fall_a: assert property ($fell(TX_DMA_REQ) |-> $past(REG_WR))
		else $error("tx dma");
endmodule // serial_fifo_checker
bind serial_fifo_status_logic serial_fifo_checker serial_fifo_checker_i (.CLK, .SYS_RST, .REG_WR,
	.REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA, .TX_WORD_REQ, .TX_WORD_VALID, .RX_WORD_PUSH,
	.FUNC_IRQ, .TX_WORD, .RX_WORD, .RX_DMA_REQ, .TX_DMA_REQ, .IRQ);

// ==== sim/serial_engine_model.sv ====
`timescale 1ns/10ps
module serial_engine_model (
	// Commands from bench
	input wire        clk, want_tx, give_rx,
	input wire [15:0] give_data,
	// Engine side
	output reg        TX_WORD_REQ = 1'b0,
	output reg        RX_WORD_PUSH = 1'b0,
	output reg [15:0] RX_WORD = 16'h0
);
	always @(posedge clk) begin
		TX_WORD_REQ <= want_tx;
		RX_WORD_PUSH <= give_rx;
		RX_WORD <= give_rx ? give_data : ~RX_WORD;
	end
endmodule // serial_engine_model

// ==== sim/serial_fifo_status_logic_tb.sv ====
`timescale 1ns/10ps
module serial_fifo_status_logic_tb;
	localparam logic [31:0] SM = 32'h001f1ffb;
	reg         CLK = 0, SYS_RST = 1, REG_WR = 0, REG_RD = 0, FUNC_IRQ = 0;
	reg  [11:0] REG_ADDR = 0;
	reg  [31:0] REG_WDATA = 0, r;
	reg         want_tx = 0, give_rx = 0, rd_d = 0;
	reg  [15:0] give_data = 0, w;
	wire [31:0] REG_RDATA;
	wire [15:0] TX_WORD, RX_WORD;
	wire        TX_WORD_REQ, TX_WORD_VALID, RX_WORD_PUSH, RX_DMA_REQ, TX_DMA_REQ, IRQ;
	logic [31:0] q_e[$], q_m[$];
	logic [15:0] tx_q[$], rx_q[$];
	int mismatches = 0, num_checks = 0, i;
	always #2 CLK = ~CLK;
	serial_fifo_status_logic serial_fifo_status_logic_i (.CLK, .SYS_RST, .REG_ADDR, .REG_WDATA,
		.REG_WR, .REG_RD, .REG_RDATA, .TX_WORD_REQ, .TX_WORD, .TX_WORD_VALID, .RX_WORD_PUSH,
		.RX_WORD, .FUNC_IRQ, .RX_DMA_REQ, .TX_DMA_REQ, .IRQ);
	serial_engine_model serial_engine_model_i (.clk(CLK), .want_tx, .give_rx, .give_data,
		.TX_WORD_REQ, .RX_WORD_PUSH, .RX_WORD);
	task automatic chk(input string n, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tick(input int n);
		REG_WR <= 1'b0;
		REG_RD <= 1'b0;
		repeat (n) @(posedge CLK);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		REG_RD <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, m = 32'hffffffff);
		q_e.push_back(e & m);
		q_m.push_back(m);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		REG_WR <= 1'b0;
		@(posedge CLK);
	endtask
	function automatic logic [31:0] stat(input int r, t, f, e);
		return {11'h0, r[4:0], 3'h0, t[4:0], r == 4, r != 0, t != 4, t == 0, f[0], 1'b0, e[1:0]};
	endfunction
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Read data and tx word monitor
	always @(posedge CLK) begin
		if (rd_d)
			chk("read data", q_e.pop_front(), REG_RDATA & q_m.pop_front());
		if (TX_WORD_VALID)
			chk("tx word", {16'h0, tx_q.pop_front()}, {16'h0, TX_WORD});
		rd_d <= REG_RD;
	end
	initial begin
		repeat (3000) @(posedge CLK);
		mismatches++;
		end_of_test();
	end
	initial begin
		r = $urandom(95);
		tick(6);
		SYS_RST <= 1'b0;
		tick(1);
		rd(12'he04, stat(0, 0, 0, 0), SM);
		rd(12'he00, 32'h10, 32'h30);
		rd(12'h004, 32'h0);
		r = $urandom;
		wr(12'he08, r);
		rd(12'he08, r, 32'h000f0f03);
		$display("map done");
		for (i = 0; i < 5; i++) begin
			w = $urandom;
			if (i < 4)
				tx_q.push_back(w);
			wr(12'he20, {16'h0, w});
		end
		rd(12'he04, stat(0, 4, 0, 1), SM);
		wr(12'he04, 32'h0);
		rd(12'he04, stat(0, 4, 0, 1), SM);
		wr(12'he04, 32'h1);
		want_tx <= 1'b1;
		tick(5);
		want_tx <= 1'b0;
		tick(4);
		rd(12'he04, stat(0, 0, 0, 1), SM);
		wr(12'he04, 32'h1);
		$display("tx done");
		for (i = 0; i < 5; i++) begin
			w = $urandom;
			if (i < 4)
				rx_q.push_back(w);
			give_data <= w;
			give_rx <= 1'b1;
			tick(1);
		end
		give_rx <= 1'b0;
		tick(3);
		rd(12'he04, stat(4, 0, 0, 2), SM);
		for (i = 0; i < 4; i++)
			rd(12'he30, {16'h0, rx_q.pop_front()}, 32'hffff);
		rd(12'he04, stat(0, 0, 0, 2), SM);
		wr(12'he04, 32'h2);
		$display("rx done");
		FUNC_IRQ <= 1'b1;
		wr(12'he10, 32'hb);
		tick(2);
		chk("irq", 1, IRQ);
		rd(12'he04, stat(0, 0, 1, 0), SM);
		FUNC_IRQ <= 1'b0;
		want_tx <= 1'b1;
		tick(1);
		want_tx <= 1'b0;
		tick(4);
		chk("irq", 1, IRQ);
		wr(12'he04, 32'h1);
		tick(2);
		chk("irq", 0, IRQ);
		$display("irq done");
		wr(12'he20, 32'h0);
		wr(12'he20, 32'h0);
		give_rx <= 1'b1;
		tick(1);
		give_rx <= 1'b0;
		tick(3);
		rd(12'he04, stat(1, 2, 0, 0), SM);
		wr(12'he00, 32'h3000);
		tick(2);
		chk("dma", 3, {RX_DMA_REQ, TX_DMA_REQ});
		wr(12'he00, 32'h33000);
		rd(12'he04, stat(0, 0, 0, 0), SM);
		chk("dma", 1, {RX_DMA_REQ, TX_DMA_REQ});
		$display("flush done");
		tick(2);
		end_of_test();
	end
endmodule // serial_fifo_status_logic_tb
